// >>> hw/tei_top.sv
// Summary of operation
// - counter mode: pin falling edge increments count
// - count pins sit on port three bits 5:4
// - clock pin port one bit 0, trigger 1
// - capture mode: clock pin clocks timer two
// - clock-out mode: clock pin carries timer-two clock
// - capture mode: trigger falling edge captures count
// - reload mode: trigger falling edge reloads count
// - up/down mode: trigger high up, low down
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
module tei_top
	import tei_pkg::*;
#(
	parameter int CNT_W  = 16,
	parameter int ADDR_W = 8
)(
	input  wire logic              clk_sys_i,        // 40 mhz clock
	input  wire logic              rst_i,            // async reset, high
	input  wire logic [7:0]        port_three_i,     // port three pins
	input  wire logic [7:0]        port_one_i,       // port one pins
	output logic                   timer_two_clock_pin_o,    // clock out
	output logic                   timer_two_clock_pin_oe_n_o, // low drives
	input  wire logic              s_axi_awvalid_i,  // write addr valid
	output logic                   s_axi_awready_o,  // write addr ready
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,   // write address
	input  wire logic              s_axi_wvalid_i,   // write data valid
	output logic                   s_axi_wready_o,   // write data ready
	input  wire logic [31:0]       s_axi_wdata_i,    // write data
	input  wire logic [3:0]        s_axi_wstrb_i,    // byte strobes
	output logic                   s_axi_bvalid_o,   // write resp valid
	input  wire logic              s_axi_bready_i,   // write resp ready
	output logic [1:0]             s_axi_bresp_o,    // write response
	input  wire logic              s_axi_arvalid_i,  // read addr valid
	output logic                   s_axi_arready_o,  // read addr ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,   // read address
	output logic                   s_axi_rvalid_o,   // read data valid
	input  wire logic              s_axi_rready_i,   // read data ready
	output logic [31:0]            s_axi_rdata_o,    // read data
	output logic [1:0]             s_axi_rresp_o     // read response
);
	import tei_pkg::*;

	// refuse widths the counters and decoder cannot serve
	if (CNT_W < 2 || CNT_W > 32 || ADDR_W < 5 || ADDR_W > 8)
	begin : g_bad_param
		$error("tei_top: unsupported CNT_W or ADDR_W");
	end

	// ----------------------------------------------------------------
	// pin sampling and falling-edge detection
	// ----------------------------------------------------------------
	logic [TEI_NPINS-1:0] pin_raw;
	logic [TEI_NPINS-1:0] sync1_q;
	logic [TEI_NPINS-1:0] sync2_q;
	logic [TEI_NPINS-1:0] prev_q;
	logic [TEI_NPINS-1:0] fall;

	// pin mapping onto the alternate port functions
	assign pin_raw[TEI_PIN_CNT0] = port_three_i[TEI_BIT_CNT0];
	assign pin_raw[TEI_PIN_CNT1] = port_three_i[TEI_BIT_CNT1];
	assign pin_raw[TEI_PIN_CLK]  = port_one_i[TEI_BIT_CLK];
	assign pin_raw[TEI_PIN_TRIG] = port_one_i[TEI_BIT_TRIG];

	// two-stage synchroniser, third stage holds last sample
	genvar gi;
	generate
		for (gi = 0; gi < TEI_NPINS; gi++)
		begin : g_pin
			always_ff @(posedge clk_sys_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					sync1_q[gi] <= 1'b1;
					sync2_q[gi] <= 1'b1;
					prev_q[gi]  <= 1'b1;
				end
				else
				begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					prev_q[gi]  <= sync2_q[gi];
				end
			end
			// one pulse per high-then-low pair
			assign fall[gi] = prev_q[gi] & ~sync2_q[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	logic              aw_full_q;
	logic              w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              awready_q;
	logic              wready_q;
	logic              wr_go;
	logic [31:0]       wmask;
	logic [7:0]        waddr;
	logic              wr_ctrl, wr_cnt0, wr_cnt1, wr_cnt2, wr_rld;
	logic              wr_hit;

	assign wr_go   = aw_full_q & w_full_q & ~bvalid_q;
	assign waddr   = 8'(aw_addr_q) & 8'hfc;
	assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
	                  {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wr_ctrl = wr_go & (waddr == TEI_OFS_CTRL);
	assign wr_cnt0 = wr_go & (waddr == TEI_OFS_CNT0);
	assign wr_cnt1 = wr_go & (waddr == TEI_OFS_CNT1);
	assign wr_cnt2 = wr_go & (waddr == TEI_OFS_CNT2);
	assign wr_rld  = wr_go & (waddr == TEI_OFS_RELOAD);
	assign wr_hit  = wr_ctrl | wr_cnt0 | wr_cnt1 | wr_cnt2 | wr_rld
	               | (waddr == TEI_OFS_CAPT) | (waddr == TEI_OFS_STATUS);

	// address and data latched in either order, answer after both
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= TEI_RESP_OKAY;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
		end
		else
		begin
			if (s_axi_awvalid_i & ~aw_full_q)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_i;
				awready_q <= 1'b0;
			end
			if (s_axi_wvalid_i & ~w_full_q)
			begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata_i;
				w_strb_q <= s_axi_wstrb_i;
				wready_q <= 1'b0;
			end
			if (wr_go)
			begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? TEI_RESP_OKAY : TEI_RESP_SLVERR;
			end
			else if (bvalid_q & s_axi_bready_i)
				bvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registers and timer logic
	// ----------------------------------------------------------------
	logic [TEI_CTRL_W-1:0] ctrl_q;
	logic [CNT_W-1:0]      cnt0_q, cnt1_q, cnt2_q, capt_q, rld_q;
	logic [CNT_W-1:0]      cnt2_d, capt_d;
	logic                  clk_out_q, clk_out_d;
	logic                  oe_n_q;
	tei_two_mode_type      mode;
	logic                  run2, two_top;
	logic [CNT_W-1:0]      wm;

	assign mode    = tei_two_mode_type'(ctrl_q[TEI_CTRL_MODE_HI:
	                                           TEI_CTRL_MODE_LO]);
	assign run2    = ctrl_q[TEI_CTRL_RUN2];
	assign two_top = &cnt2_q;
	assign wm     = wmask[CNT_W-1:0];

	// timer-two next count per mode
	always_comb
	begin
		cnt2_d    = cnt2_q;
		capt_d    = capt_q;
		clk_out_d = clk_out_q;
		if (run2)
		begin
			case (mode)
				TEI_TWO_CAPTURE:
				begin
					if (fall[TEI_PIN_CLK])
						cnt2_d = cnt2_q + 1'b1;
					if (fall[TEI_PIN_TRIG])
						capt_d = cnt2_q;
				end
				TEI_TWO_RELOAD:
				begin
					if (fall[TEI_PIN_TRIG])
						cnt2_d = rld_q;
					else if (fall[TEI_PIN_CLK])
						cnt2_d = two_top ? rld_q : cnt2_q + 1'b1;
				end
				TEI_TWO_UPDOWN:
				begin
					if (fall[TEI_PIN_CLK])
						cnt2_d = sync2_q[TEI_PIN_TRIG] ?
							cnt2_q + 1'b1 : cnt2_q - 1'b1;
				end
				TEI_TWO_CLKOUT:
				begin
					cnt2_d = two_top ? rld_q : cnt2_q + 1'b1;
					if (two_top)
						clk_out_d = ~clk_out_q;
				end
				default:
					cnt2_d = cnt2_q;
			endcase
		end
		if (wr_cnt2)
			cnt2_d = (cnt2_q & ~wm) | (w_data_q[CNT_W-1:0] & wm);
	end

	// software writes win over a same-cycle count
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_q    <= TEI_CTRL_RST;
			cnt0_q    <= '0;
			cnt1_q    <= '0;
			cnt2_q    <= '0;
			capt_q    <= '0;
			rld_q     <= '0;
			clk_out_q <= 1'b1;
			oe_n_q    <= 1'b1;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= w_data_q[TEI_CTRL_W-1:0];
			if (wr_cnt0)
				cnt0_q <= (cnt0_q & ~wm) | (w_data_q[CNT_W-1:0] & wm);
			else if (ctrl_q[TEI_CTRL_CNT0_EN] & fall[TEI_PIN_CNT0])
				cnt0_q <= cnt0_q + 1'b1;
			if (wr_cnt1)
				cnt1_q <= (cnt1_q & ~wm) | (w_data_q[CNT_W-1:0] & wm);
			else if (ctrl_q[TEI_CTRL_CNT1_EN] & fall[TEI_PIN_CNT1])
				cnt1_q <= cnt1_q + 1'b1;
			if (wr_rld)
				rld_q <= (rld_q & ~wm) | (w_data_q[CNT_W-1:0] & wm);
			cnt2_q    <= cnt2_d;
			capt_q    <= capt_d;
			clk_out_q <= clk_out_d;
			oe_n_q    <= ~(run2 & (mode == TEI_TWO_CLKOUT));
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	logic        rvalid_q;
	logic        arready_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [7:0]  raddr;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic        rd_take;

	assign raddr   = 8'(s_axi_araddr_i) & 8'hfc;
	assign rd_take = s_axi_arvalid_i & ~rvalid_q;
	assign rd_hit  = (raddr <= TEI_OFS_STATUS);
	assign rd_word =
		(raddr == TEI_OFS_CTRL)   ? 32'(ctrl_q) :
		(raddr == TEI_OFS_CNT0)   ? 32'(cnt0_q) :
		(raddr == TEI_OFS_CNT1)   ? 32'(cnt1_q) :
		(raddr == TEI_OFS_CNT2)   ? 32'(cnt2_q) :
		(raddr == TEI_OFS_CAPT)   ? 32'(capt_q) :
		(raddr == TEI_OFS_RELOAD) ? 32'(rld_q)  :
		(raddr == TEI_OFS_STATUS) ?
			32'({sync2_q[TEI_PIN_TRIG], sync2_q}) : 32'h0000_0000;

	// one read at a time, data registered
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
			rdata_q   <= '0;
			rresp_q   <= TEI_RESP_OKAY;
		end
		else if (rd_take)
		begin
			rvalid_q  <= 1'b1;
			arready_q <= 1'b0;
			rdata_q   <= rd_word;
			rresp_q   <= rd_hit ? TEI_RESP_OKAY : TEI_RESP_SLVERR;
		end
		else if (s_axi_rready_i)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o  = wready_q;
	assign s_axi_bvalid_o  = bvalid_q;
	assign s_axi_bresp_o   = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o  = rvalid_q;
	assign s_axi_rdata_o   = rdata_q;
	assign s_axi_rresp_o   = rresp_q;
	assign timer_two_clock_pin_o      = clk_out_q;
	assign timer_two_clock_pin_oe_n_o = oe_n_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_cnt0_inc;
		@(posedge clk_sys_i) disable iff (rst_i)
		ctrl_q[TEI_CTRL_CNT0_EN] && fall[TEI_PIN_CNT0] && !wr_cnt0
		|=> cnt0_q == CNT_W'($past(cnt0_q) + 1'b1);
	endproperty
	a_cnt0_inc: assert property (p_cnt0_inc)
		else $error("count zero missed a pin edge");

	property p_cnt1_hold;
		@(posedge clk_sys_i) disable iff (rst_i)
		!fall[TEI_PIN_CNT1] && !wr_cnt1 |=> $stable(cnt1_q);
	endproperty
	a_cnt1_hold: assert property (p_cnt1_hold)
		else $error("count one moved without an edge");

	property p_pin_map3;
		@(posedge clk_sys_i) disable iff (rst_i)
		##2 sync2_q[TEI_PIN_CNT1:TEI_PIN_CNT0] ==
			$past(port_three_i[TEI_BIT_CNT1:TEI_BIT_CNT0], 2);
	endproperty
	a_pin_map3: assert property (p_pin_map3)
		else $error("count pins not taken from port three");

	property p_pin_map1;
		@(posedge clk_sys_i) disable iff (rst_i)
		##2 sync2_q[TEI_PIN_TRIG:TEI_PIN_CLK] ==
			$past(port_one_i[TEI_BIT_TRIG:TEI_BIT_CLK], 2);
	endproperty
	a_pin_map1: assert property (p_pin_map1)
		else $error("timer-two pins not taken from port one");

	property p_capt_clk;
		@(posedge clk_sys_i) disable iff (rst_i)
		run2 && mode == TEI_TWO_CAPTURE && fall[TEI_PIN_CLK] && !wr_cnt2
		|=> cnt2_q == CNT_W'($past(cnt2_q) + 1'b1);
	endproperty
	a_capt_clk: assert property (p_capt_clk)
		else $error("capture mode did not count clock pin");

	property p_clkout_oe;
		@(posedge clk_sys_i) disable iff (rst_i)
		run2 && mode == TEI_TWO_CLKOUT |=> !timer_two_clock_pin_oe_n_o;
	endproperty
	a_clkout_oe: assert property (p_clkout_oe)
		else $error("clock pin not driven in clock-out mode");

	property p_capture;
		@(posedge clk_sys_i) disable iff (rst_i)
		run2 && mode == TEI_TWO_CAPTURE && fall[TEI_PIN_TRIG]
		|=> capt_q == $past(cnt2_q);
	endproperty
	a_capture: assert property (p_capture)
		else $error("trigger edge did not capture");

	property p_reload;
		@(posedge clk_sys_i) disable iff (rst_i)
		run2 && mode == TEI_TWO_RELOAD && fall[TEI_PIN_TRIG] && !wr_cnt2
		|=> cnt2_q == $past(rld_q);
	endproperty
	a_reload: assert property (p_reload)
		else $error("trigger edge did not reload");

	property p_down;
		@(posedge clk_sys_i) disable iff (rst_i)
		run2 && mode == TEI_TWO_UPDOWN && fall[TEI_PIN_CLK]
		&& !sync2_q[TEI_PIN_TRIG] && !wr_cnt2
		|=> cnt2_q == CNT_W'($past(cnt2_q) - 1'b1);
	endproperty
	a_down: assert property (p_down)
		else $error("low trigger level did not count down");

	property p_once;
		@(posedge clk_sys_i) disable iff (rst_i)
		fall[TEI_PIN_TRIG] == $fell(sync2_q[TEI_PIN_TRIG]);
	endproperty
	a_once: assert property (p_once)
		else $error("trigger edge not acted on exactly once");

	c_capture: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		run2 && mode == TEI_TWO_CAPTURE && fall[TEI_PIN_TRIG]);
	c_reload: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		run2 && mode == TEI_TWO_RELOAD && fall[TEI_PIN_TRIG]);
	c_clkout: cover property (@(posedge clk_sys_i) disable iff (rst_i)
		$changed(timer_two_clock_pin_o));

endmodule // tei_top

// >>> shared/tei_pkg.sv
package tei_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] TEI_OFS_CTRL   = 8'h00;
	localparam logic [7:0] TEI_OFS_CNT0   = 8'h04;
	localparam logic [7:0] TEI_OFS_CNT1   = 8'h08;
	localparam logic [7:0] TEI_OFS_CNT2   = 8'h0c;
	localparam logic [7:0] TEI_OFS_CAPT   = 8'h10;
	localparam logic [7:0] TEI_OFS_RELOAD = 8'h14;
	localparam logic [7:0] TEI_OFS_STATUS = 8'h18;

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	localparam int TEI_CTRL_CNT0_EN = 0;
	localparam int TEI_CTRL_CNT1_EN = 1;
	localparam int TEI_CTRL_MODE_LO = 2;
	localparam int TEI_CTRL_MODE_HI = 3;
	localparam int TEI_CTRL_RUN2    = 4;
	localparam int TEI_CTRL_W       = 5;
	localparam logic [4:0] TEI_CTRL_RST = 5'h00;

	// ----------------------------------------------------------------
	// pin positions and pin index in the sampling chain
	// ----------------------------------------------------------------
	localparam int TEI_BIT_CNT0 = 4;
	localparam int TEI_BIT_CNT1 = 5;
	localparam int TEI_BIT_CLK  = 0;
	localparam int TEI_BIT_TRIG = 1;
	localparam int TEI_PIN_CNT0 = 0;
	localparam int TEI_PIN_CNT1 = 1;
	localparam int TEI_PIN_CLK  = 2;
	localparam int TEI_PIN_TRIG = 3;
	localparam int TEI_NPINS    = 4;

	// status fields: pin levels in [3:0], direction in bit 4
	localparam int TEI_STAT_DIR = 4;

	// axi responses
	localparam logic [1:0] TEI_RESP_OKAY   = 2'h0;
	localparam logic [1:0] TEI_RESP_SLVERR = 2'h2;

	// timer-two modes
	typedef enum logic [1:0] {
		TEI_TWO_CAPTURE,
		TEI_TWO_RELOAD,
		TEI_TWO_UPDOWN,
		TEI_TWO_CLKOUT
	} tei_two_mode_type;

endpackage

// >>> tb/tei_pin_src.sv
module tei_pin_src
	import tei_pkg::*;
(
	input  wire logic       clk_sys_i,    // system clock
	output logic      [7:0] port_three_o, // port three levels
	output logic      [7:0] port_one_o    // port one levels
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// pin sources
	// ----------------------------------------------------------------
	// idle pins sit at the pullup level
	initial
	begin
		port_three_o = 8'hff;
		port_one_o   = 8'hff;
	end

	// one level, held three clocks so the sampler sees it
	task automatic drive(input int pin, input logic v);
		@(posedge clk_sys_i);
		case (pin)
			TEI_PIN_CNT0: port_three_o[TEI_BIT_CNT0] <= v;
			TEI_PIN_CNT1: port_three_o[TEI_BIT_CNT1] <= v;
			TEI_PIN_CLK:  port_one_o[TEI_BIT_CLK] <= v;
			default:      port_one_o[TEI_BIT_TRIG] <= v;
		endcase
		repeat (2) @(posedge clk_sys_i);
	endtask

	// n low-then-high pairs, ending high
	task automatic pulse(input int pin, input int n);
		repeat (n)
		begin
			drive(pin, 1'b0);
			drive(pin, 1'b1);
		end
	endtask
endmodule // tei_pin_src

// >>> tb/tb_tei_top.sv
module tb_tei_top
	import tei_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk_sys_i, rst_i, pin_o, oe_n;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, port_three, port_one, port_one_w;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rd_r;
	int          fails, cmp_count, cyc;

	// clock pin wire: device drives it while its enable is low
	assign port_one_w = {port_one[7:1], oe_n ? port_one[0] : pin_o};

	tei_pin_src i_src (.clk_sys_i(clk_sys_i),
		.port_three_o(port_three), .port_one_o(port_one));

	tei_top i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.port_three_i(port_three), .port_one_i(port_one_w),
		.timer_two_clock_pin_o(pin_o),
		.timer_two_clock_pin_oe_n_o(oe_n),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp));

	// 40 mhz clock
	always #12.5 clk_sys_i = ~clk_sys_i;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("compares=%0d mismatches=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask

	// write, each channel released at its own take
	task automatic wchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w)
		begin
			@(posedge clk_sys_i);
			if (aw && awready)
			begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready)
			begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys_i); while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	// read and compare data and response
	task automatic rchk(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk_sys_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_sys_i); while (rvalid !== 1'b1);
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values and an unmapped place
	task automatic t_reset();
		rchk(TEI_OFS_CTRL, 32'h0, TEI_RESP_OKAY);
		rchk(TEI_OFS_STATUS, 32'h1f, TEI_RESP_OKAY);
		rchk(8'h1c, 32'h0, TEI_RESP_SLVERR);
		wchk(8'h1c, 32'h1, TEI_RESP_SLVERR);
	endtask

	// count pins, count zero disabled then both enabled
	task automatic t_count01();
		i_src.pulse(TEI_PIN_CNT0, 2);
		rchk(TEI_OFS_CNT0, 32'h0, TEI_RESP_OKAY);
		wchk(TEI_OFS_CTRL, 32'h3, TEI_RESP_OKAY);
		i_src.pulse(TEI_PIN_CNT0, 3);
		i_src.pulse(TEI_PIN_CNT1, 2);
		rchk(TEI_OFS_CNT0, 32'h3, TEI_RESP_OKAY);
		rchk(TEI_OFS_CNT1, 32'h2, TEI_RESP_OKAY);
	endtask

	// capture mode: clock pin counts, trigger captures
	task automatic t_capture();
		wchk(TEI_OFS_CTRL, 32'h10, TEI_RESP_OKAY);
		i_src.pulse(TEI_PIN_CLK, 4);
		rchk(TEI_OFS_CNT2, 32'h4, TEI_RESP_OKAY);
		i_src.pulse(TEI_PIN_TRIG, 1);
		rchk(TEI_OFS_CAPT, 32'h4, TEI_RESP_OKAY);
		wchk(TEI_OFS_CAPT, 32'h9, TEI_RESP_OKAY);
		rchk(TEI_OFS_CAPT, 32'h4, TEI_RESP_OKAY);
	endtask

	// reload mode: trigger fall loads the reload value
	task automatic t_reload();
		wchk(TEI_OFS_RELOAD, 32'h1234, TEI_RESP_OKAY);
		wchk(TEI_OFS_CTRL, 32'h14, TEI_RESP_OKAY);
		i_src.pulse(TEI_PIN_CLK, 2);
		rchk(TEI_OFS_CNT2, 32'h6, TEI_RESP_OKAY);
		i_src.pulse(TEI_PIN_TRIG, 1);
		i_src.pulse(TEI_PIN_CLK, 1);
		rchk(TEI_OFS_CNT2, 32'h1235, TEI_RESP_OKAY);
	endtask

	// up/down mode: trigger level picks direction
	task automatic t_updown();
		wchk(TEI_OFS_CNT2, 32'ha, TEI_RESP_OKAY);
		wchk(TEI_OFS_CTRL, 32'h18, TEI_RESP_OKAY);
		i_src.pulse(TEI_PIN_CLK, 3);
		rchk(TEI_OFS_CNT2, 32'hd, TEI_RESP_OKAY);
		i_src.drive(TEI_PIN_TRIG, 1'b0);
		rchk(TEI_OFS_STATUS, 32'h07, TEI_RESP_OKAY);
		i_src.pulse(TEI_PIN_CLK, 5);
		rchk(TEI_OFS_CNT2, 32'h8, TEI_RESP_OKAY);
		i_src.drive(TEI_PIN_TRIG, 1'b1);
	endtask

	// clock-out mode: pin driven and toggling
	task automatic t_clkout();
		int tg;
		logic prev;
		tg = 0;
		wchk(TEI_OFS_RELOAD, 32'hfff0, TEI_RESP_OKAY);
		wchk(TEI_OFS_CNT2, 32'hfff0, TEI_RESP_OKAY);
		wchk(TEI_OFS_CTRL, 32'h1c, TEI_RESP_OKAY);
		@(posedge clk_sys_i);
		chk({31'h0, oe_n}, 32'h0);
		prev = pin_o;
		repeat (64)
		begin
			@(posedge clk_sys_i);
			if (pin_o !== prev)
				tg++;
			prev = pin_o;
		end
		chk(32'(tg >= 3 && tg <= 5), 32'h1);
		wchk(TEI_OFS_CTRL, 32'h0, TEI_RESP_OKAY);
		@(posedge clk_sys_i);
		chk({31'h0, oe_n}, 32'h1);
	endtask

	// ----------------------------------------------------------------
	// main sequence and timeout
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys_i = 1'b0;
		rst_i = 1'b1;
		{awvalid, wvalid, arvalid} = 3'h0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		fails = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_reset();
		t_count01();
		t_capture();
		t_reload();
		t_updown();
		t_clkout();
		conclude();
	end

	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			conclude();
		end
	end
endmodule // tb_tei_top
